// ===== design/adc_ctl_pkg.sv
package adc_ctl_pkg;

   // ****************************************
   // Widths
   // ****************************************
   localparam int CODE_W = 10;
   localparam int WORD_W = 16;
   localparam int SEL_W = 5;
   localparam int ADDR_W = 12;
   localparam int ST_W = 3;
   localparam int SRC_W = 5;
   localparam int JUSTIFY_SHIFT = 6;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 12'h000;
   localparam logic [ADDR_W-1:0] GT_ADDR = 12'h004;
   localparam logic [ADDR_W-1:0] LT_ADDR = 12'h008;
   localparam logic [ADDR_W-1:0] DATA_ADDR = 12'h00c;
   localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h010;
   localparam logic [ADDR_W-1:0] MASK_ADDR = 12'h014;
   localparam logic [7:0] SEL_INDEX = 8'hbb;
   localparam logic [ADDR_W-1:0] SEL_ADDR = {2'b00, SEL_INDEX, 2'b00};

   // ****************************************
   // Fields and reset values
   // ****************************************
   localparam int CTRL_LEFT_BIT = 0;
   localparam int ST_WIN = 0;
   localparam int ST_DONE = 1;
   localparam int ST_UNSAFE = 2;
   localparam logic [WORD_W-1:0] GT_RESET = 16'hffff;
   localparam logic [WORD_W-1:0] LT_RESET = 16'h0000;
   localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
   localparam logic [ST_W-1:0] ST_RESET = 3'h0;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

   // ****************************************
   // Selector codes
   // ****************************************
   localparam logic [SEL_W-1:0] CODE_PORT_FIRST = 5'h00;
   localparam logic [SEL_W-1:0] CODE_PORT_LAST = 5'h0f;
   localparam logic [SEL_W-1:0] CODE_P2_FIRST = 5'h10;
   localparam logic [SEL_W-1:0] CODE_P2_LAST = 5'h16;
   localparam logic [SEL_W-1:0] CODE_TEMP = 5'h1b;
   localparam logic [SEL_W-1:0] CODE_BAT = 5'h1c;
   localparam logic [SEL_W-1:0] CODE_REG = 5'h1d;
   localparam logic [SEL_W-1:0] CODE_MAIN = 5'h1e;
   localparam logic [SEL_W-1:0] CODE_GND = 5'h1f;
   localparam logic [SEL_W-1:0] SEL_RESET = CODE_GND;

   // One-hot internal source positions
   localparam int SRC_TEMP = 0;
   localparam int SRC_BAT = 1;
   localparam int SRC_REG = 2;
   localparam int SRC_MAIN = 3;
   localparam int SRC_GND = 4;
   localparam logic [SRC_W-1:0] SRC_GND_ONEHOT = 5'h10;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
   } conv_t;

   typedef struct packed {
      logic [SEL_W-1:0] code;
      logic pin_en;
      logic [SRC_W-1:0] internal;
      logic reserved;
   } route_t;

   localparam route_t ROUTE_RESET = {SEL_RESET, 1'b0, SRC_GND_ONEHOT, 1'b0};

endpackage

// ===== design/window_compare.sv
module window_compare
(
   input wire logic [adc_ctl_pkg::WORD_W-1:0] word,
   input wire logic [adc_ctl_pkg::WORD_W-1:0] gt_thr,
   input wire logic [adc_ctl_pkg::WORD_W-1:0] lt_thr,
   output logic inside_mode,
   output logic hit
);

   // ****************************************
   // Window detection
   // ****************************************
   // Mode follows the threshold order
   always_comb
   begin
      inside_mode = lt_thr > gt_thr;
      if (inside_mode)
      begin
         hit = (word > gt_thr) && (word < lt_thr);
      end
      else
      begin
         hit = (word < lt_thr) || (word > gt_thr);
      end
   end

endmodule

// ===== design/adc_window_select.sv
// Contract
// - Single-ended result is unsigned 10-bit code
// - Inside window: flag when gt < word < lt
// - Outside window: flag when word outside bounds
// - Selector field bits 4:0, resets to ground
// - Selector bits 7:5 read zero, writes ignored
// - Codes 11011 to 11111 pick internal sources
// - Low codes pick port pins, port 2 optional
//
// Implementation choice: the APB register port.
module adc_window_select
#(
   parameter bit HAS_PORT2 = 1'b1
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [adc_ctl_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire adc_ctl_pkg::conv_t conv,
   output adc_ctl_pkg::route_t route,
   output logic irq
);

   // ****************************************
   // Functions
   // ****************************************
   // Inclusive code range test
   function automatic logic in_range(input logic [adc_ctl_pkg::SEL_W-1:0] c,
                                     input logic [adc_ctl_pkg::SEL_W-1:0] lo,
                                     input logic [adc_ctl_pkg::SEL_W-1:0] hi);
      in_range = (c >= lo) && (c <= hi);
   endfunction

   // Selector code to analog routing
   function automatic adc_ctl_pkg::route_t decode_route(
      input logic [adc_ctl_pkg::SEL_W-1:0] c);
      adc_ctl_pkg::route_t r;
      r = '0;
      r.code = c;
      if (in_range(c, adc_ctl_pkg::CODE_PORT_FIRST, adc_ctl_pkg::CODE_PORT_LAST))
      begin
         r.pin_en = 1'b1;
      end
      else if (in_range(c, adc_ctl_pkg::CODE_P2_FIRST, adc_ctl_pkg::CODE_P2_LAST))
      begin
         r.pin_en = HAS_PORT2;
         r.reserved = !HAS_PORT2;
      end
      else
      begin
         case (c)
            adc_ctl_pkg::CODE_TEMP: r.internal[adc_ctl_pkg::SRC_TEMP] = 1'b1;
            adc_ctl_pkg::CODE_BAT: r.internal[adc_ctl_pkg::SRC_BAT] = 1'b1;
            adc_ctl_pkg::CODE_REG: r.internal[adc_ctl_pkg::SRC_REG] = 1'b1;
            adc_ctl_pkg::CODE_MAIN: r.internal[adc_ctl_pkg::SRC_MAIN] = 1'b1;
            adc_ctl_pkg::CODE_GND: r.internal[adc_ctl_pkg::SRC_GND] = 1'b1;
            default: r.reserved = 1'b1;
         endcase
      end
      decode_route = r;
   endfunction

   // Mapped address test
   function automatic logic is_mapped(input logic [adc_ctl_pkg::ADDR_W-1:0] a);
      is_mapped = (a == adc_ctl_pkg::CTRL_ADDR) || (a == adc_ctl_pkg::GT_ADDR)
         || (a == adc_ctl_pkg::LT_ADDR) || (a == adc_ctl_pkg::DATA_ADDR)
         || (a == adc_ctl_pkg::STAT_ADDR) || (a == adc_ctl_pkg::MASK_ADDR)
         || (a == adc_ctl_pkg::SEL_ADDR);
   endfunction

   // ****************************************
   // Declarations
   // ****************************************
   logic [adc_ctl_pkg::SEL_W-1:0] sel_r;
   logic left_r;
   logic [adc_ctl_pkg::WORD_W-1:0] gt_r;
   logic [adc_ctl_pkg::WORD_W-1:0] lt_r;
   logic [adc_ctl_pkg::WORD_W-1:0] word_r;
   logic [adc_ctl_pkg::ST_W-1:0] st_r;
   logic [adc_ctl_pkg::ST_W-1:0] st_nxt;
   logic [adc_ctl_pkg::ST_W-1:0] st_set;
   logic [adc_ctl_pkg::ST_W-1:0] mask_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_word;
   logic err_r;
   logic wr_en;
   logic [adc_ctl_pkg::WORD_W-1:0] new_word;
   logic inside_mode;
   logic hit;
   logic unsafe_sw;

   // ****************************************
   // APB access
   // ****************************************
   // Zero wait states; data prepared in setup
   assign pready = psel && penable;
   assign pslverr = pready && err_r;
   assign prdata = prdata_r;
   assign wr_en = pready && pwrite && !err_r;

   // Read mux
   always_comb
   begin
      rd_word = adc_ctl_pkg::BUS_ZERO;
      case (paddr)
         adc_ctl_pkg::CTRL_ADDR: rd_word[adc_ctl_pkg::CTRL_LEFT_BIT] = left_r;
         adc_ctl_pkg::GT_ADDR: rd_word[adc_ctl_pkg::WORD_W-1:0] = gt_r;
         adc_ctl_pkg::LT_ADDR: rd_word[adc_ctl_pkg::WORD_W-1:0] = lt_r;
         adc_ctl_pkg::DATA_ADDR: rd_word[adc_ctl_pkg::WORD_W-1:0] = word_r;
         adc_ctl_pkg::STAT_ADDR: rd_word[adc_ctl_pkg::ST_W-1:0] = st_r;
         adc_ctl_pkg::MASK_ADDR: rd_word[adc_ctl_pkg::ST_W-1:0] = mask_r;
         adc_ctl_pkg::SEL_ADDR: rd_word[adc_ctl_pkg::SEL_W-1:0] = sel_r;
         default: rd_word = adc_ctl_pkg::BUS_ZERO;
      endcase
   end

   // Read data and error captured in setup
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r <= adc_ctl_pkg::BUS_ZERO;
         err_r <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata_r <= pwrite ? adc_ctl_pkg::BUS_ZERO : rd_word;
         err_r <= !is_mapped(paddr);
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Justification and thresholds
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         left_r <= 1'b0;
         gt_r <= adc_ctl_pkg::GT_RESET;
         lt_r <= adc_ctl_pkg::LT_RESET;
         mask_r <= adc_ctl_pkg::ST_RESET;
      end
      else if (wr_en)
      begin
         case (paddr)
            adc_ctl_pkg::CTRL_ADDR: left_r <= pwdata[adc_ctl_pkg::CTRL_LEFT_BIT];
            adc_ctl_pkg::GT_ADDR: gt_r <= pwdata[adc_ctl_pkg::WORD_W-1:0];
            adc_ctl_pkg::LT_ADDR: lt_r <= pwdata[adc_ctl_pkg::WORD_W-1:0];
            adc_ctl_pkg::MASK_ADDR: mask_r <= pwdata[adc_ctl_pkg::ST_W-1:0];
            default: mask_r <= mask_r;
         endcase
      end
   end

   // Input selector, upper bits dropped
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_r <= adc_ctl_pkg::SEL_RESET;
      end
      else if (wr_en && (paddr == adc_ctl_pkg::SEL_ADDR))
      begin
         sel_r <= pwdata[adc_ctl_pkg::SEL_W-1:0];
      end
   end

   // Routing follows the selector
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         route <= adc_ctl_pkg::ROUTE_RESET;
      end
      else
      begin
         route <= decode_route(sel_r);
      end
   end

   // Direct jump to sensor not from ground
   assign unsafe_sw = wr_en && (paddr == adc_ctl_pkg::SEL_ADDR)
      && (pwdata[adc_ctl_pkg::SEL_W-1:0] == adc_ctl_pkg::CODE_TEMP)
      && (sel_r != adc_ctl_pkg::CODE_GND) && (sel_r != adc_ctl_pkg::CODE_TEMP);

   // ****************************************
   // Conversion word and window
   // ****************************************
   // Justify the 10-bit code
   always_comb
   begin
      new_word = {{adc_ctl_pkg::JUSTIFY_SHIFT{1'b0}}, conv.code};
      if (left_r)
      begin
         new_word = {conv.code, {adc_ctl_pkg::JUSTIFY_SHIFT{1'b0}}};
      end
   end

   // Latest conversion word
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         word_r <= adc_ctl_pkg::WORD_RESET;
      end
      else if (conv.valid)
      begin
         word_r <= new_word;
      end
   end

   window_compare u_cmp
   (
      .word(new_word),
      .gt_thr(gt_r),
      .lt_thr(lt_r),
      .inside_mode(inside_mode),
      .hit(hit)
   );

   // ****************************************
   // Status and interrupt
   // ****************************************
   // Events; set beats write-one clear
   always_comb
   begin
      st_set = adc_ctl_pkg::ST_RESET;
      st_set[adc_ctl_pkg::ST_WIN] = conv.valid && hit;
      st_set[adc_ctl_pkg::ST_DONE] = conv.valid;
      st_set[adc_ctl_pkg::ST_UNSAFE] = unsafe_sw;
      st_nxt = st_r;
      if (wr_en && (paddr == adc_ctl_pkg::STAT_ADDR))
      begin
         st_nxt = st_r & ~pwdata[adc_ctl_pkg::ST_W-1:0];
      end
      st_nxt = st_nxt | st_set;
   end

   // Sticky status and level interrupt
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r <= adc_ctl_pkg::ST_RESET;
         irq <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         irq <= |(st_nxt & mask_r);
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_code_right;
      @(posedge pclk) disable iff (!presetn)
      conv.valid && !left_r |=> word_r == {{adc_ctl_pkg::JUSTIFY_SHIFT{1'b0}}, $past(conv.code)};
   endproperty
   a_code_right: assert property (p_code_right)
      else $error("right-justified word wrong");
   property p_inside;
      @(posedge pclk) disable iff (!presetn)
      conv.valid && (lt_r > gt_r) && (new_word > gt_r) && (new_word < lt_r)
      |=> st_r[adc_ctl_pkg::ST_WIN] ##1 irq || !mask_r[adc_ctl_pkg::ST_WIN]
         || $past(wr_en);
   endproperty
   a_inside: assert property (p_inside)
      else $error("inside hit missed");
   property p_outside;
      @(posedge pclk) disable iff (!presetn)
      conv.valid && (lt_r <= gt_r) && ((new_word < lt_r) || (new_word > gt_r))
      |=> st_r[adc_ctl_pkg::ST_WIN];
   endproperty
   a_outside: assert property (p_outside)
      else $error("outside hit missed");
   property p_mode;
      @(posedge pclk) disable iff (!presetn)
      conv.valid && (lt_r > gt_r) && (new_word == lt_r)
      && !st_r[adc_ctl_pkg::ST_WIN] |=> !st_r[adc_ctl_pkg::ST_WIN];
   endproperty
   a_mode: assert property (p_mode)
      else $error("boundary word flagged in inside mode");
   property p_sel_write;
      @(posedge pclk) disable iff (!presetn)
      wr_en && (paddr == adc_ctl_pkg::SEL_ADDR)
      |=> sel_r == $past(pwdata[adc_ctl_pkg::SEL_W-1:0]) ##1 route.code == $past(sel_r);
   endproperty
   a_sel_write: assert property (p_sel_write)
      else $error("selector write not routed");
   property p_sel_upper;
      @(posedge pclk) disable iff (!presetn)
      psel && !penable && !pwrite && (paddr == adc_ctl_pkg::SEL_ADDR)
      |=> prdata[31:adc_ctl_pkg::SEL_W] == '0 && prdata[adc_ctl_pkg::SEL_W-1:0] == sel_r;
   endproperty
   a_sel_upper: assert property (p_sel_upper)
      else $error("selector upper bits not zero");
   property p_temp_route;
      @(posedge pclk) disable iff (!presetn)
      sel_r == adc_ctl_pkg::CODE_TEMP
      |=> route.internal[adc_ctl_pkg::SRC_TEMP] && $onehot(route.internal) && !route.pin_en;
   endproperty
   a_temp_route: assert property (p_temp_route)
      else $error("sensor code misrouted");
   property p_port_route;
      @(posedge pclk) disable iff (!presetn)
      sel_r <= adc_ctl_pkg::CODE_PORT_LAST |=> route.pin_en && route.internal == '0;
   endproperty
   a_port_route: assert property (p_port_route)
      else $error("port code misrouted");
   property p_unsafe;
      @(posedge pclk) disable iff (!presetn)
      unsafe_sw |=> st_r[adc_ctl_pkg::ST_UNSAFE];
   endproperty
   a_unsafe: assert property (p_unsafe)
      else $error("unsafe sensor switch not flagged");
   property p_irq;
      @(posedge pclk) disable iff (!presetn)
      |(st_r & mask_r) && $stable(mask_r) |-> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");
endmodule

// ===== verif/conv_source_model.sv
module conv_source_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   input wire logic [adc_ctl_pkg::CODE_W-1:0] code_in,
   output adc_ctl_pkg::conv_t conv
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Converter result strobe
   // ****************************************
   // One-cycle valid pulse; code lines toggle when idle so stale codes never look valid
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         conv <= '0;
      end
      else
      begin
         conv.valid <= start;
         conv.code <= start ? code_in : ~conv.code;
      end
   end
endmodule

// ===== verif/adc_window_select_tb.sv
module adc_window_select_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Signals
   // ****************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [adc_ctl_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   adc_ctl_pkg::conv_t conv;
   adc_ctl_pkg::route_t route;
   adc_ctl_pkg::route_t route_np;
   logic irq;
   logic start = 1'b0;
   logic [adc_ctl_pkg::CODE_W-1:0] code_in = '0;
   logic [31:0] rd;
   logic err;
   logic left_j = 1'b0;
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;

   adc_window_select #(.HAS_PORT2(1'b1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv(conv), .route(route), .irq(irq));

   // Variant without the optional port-2 pins, same bus
   adc_window_select #(.HAS_PORT2(1'b0)) dut_no_port2 (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(), .pready(), .pslverr(), .conv(conv), .route(route_np), .irq());

   conv_source_model src (.pclk(pclk), .presetn(presetn), .start(start), .code_in(code_in),
      .conv(conv));

   // Clock and hang guard
   always #12.5 pclk = ~pclk;

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         final_report();
      end
   end

   // ****************************************
   // Tasks
   // ****************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready, the hang guard ends a lost answer
   task automatic apb(input logic w, input logic [adc_ctl_pkg::ADDR_W-1:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input string name, input logic [adc_ctl_pkg::ADDR_W-1:0] a,
                        input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(name, rd, exp);
   endtask

   // Expected route for a selector code
   function automatic logic [11:0] exp_route(input logic [4:0] c, input logic p2);
      logic [4:0] oh;
      oh = 5'h01 << (c - 5'h1b);
      if (c <= 5'h0f || (p2 && c <= 5'h16))
         return {c, 1'b1, 5'h00, 1'b0};
      if (c >= 5'h1b)
         return {c, 1'b0, oh, 1'b0};
      return {c, 1'b0, 5'h00, 1'b1};
   endfunction

   task automatic set_sel(input logic [4:0] c);
      if (c == adc_ctl_pkg::CODE_TEMP)
         apb(1'b1, adc_ctl_pkg::SEL_ADDR, {27'h000_0000, adc_ctl_pkg::CODE_GND});
      apb(1'b1, adc_ctl_pkg::SEL_ADDR, {27'h000_0000, c});
      repeat (3) @(posedge pclk);
      check("route", route, exp_route(c, 1'b1));
      check("route no port2", route_np, exp_route(c, 1'b0));
      rdchk("sel", adc_ctl_pkg::SEL_ADDR, {27'h000_0000, c});
   endtask

   // One conversion, then status, data word and clear
   task automatic win(input logic [9:0] c, input logic e);
      @(posedge pclk);
      start <= 1'b1;
      code_in <= c;
      @(posedge pclk);
      start <= 1'b0;
      repeat (3) @(posedge pclk);
      rdchk("status", adc_ctl_pkg::STAT_ADDR, {30'h0000_0000, 1'b1, e});
      rdchk("word", adc_ctl_pkg::DATA_ADDR,
            left_j ? {16'h0000, c, 6'h00} : {22'h00_0000, c});
      apb(1'b1, adc_ctl_pkg::STAT_ADDR, 32'h0000_0007);
   endtask

   task automatic thr(input logic [15:0] g, input logic [15:0] l);
      apb(1'b1, adc_ctl_pkg::GT_ADDR, {16'h0000, g});
      apb(1'b1, adc_ctl_pkg::LT_ADDR, {16'h0000, l});
   endtask

   task automatic reset_check();
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      check("route reset", route, adc_ctl_pkg::ROUTE_RESET);
      check("irq reset", irq, 1'b0);
      rdchk("sel reset", adc_ctl_pkg::SEL_ADDR, 32'h0000_001f);
      rdchk("gt reset", adc_ctl_pkg::GT_ADDR, 32'h0000_ffff);
      rdchk("lt reset", adc_ctl_pkg::LT_ADDR, 32'h0000_0000);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      reset_check();
      // Inside, outside and equal thresholds, right justified
      thr(16'h0040, 16'h0080);
      win(10'h03f, 1'b0);
      win(10'h040, 1'b0);
      win(10'h041, 1'b1);
      win(10'h07f, 1'b1);
      win(10'h080, 1'b0);
      thr(16'h0080, 16'h0040);
      win(10'h03f, 1'b1);
      win(10'h040, 1'b0);
      win(10'h080, 1'b0);
      win(10'h081, 1'b1);
      thr(16'h0040, 16'h0040);
      win(10'h040, 1'b0);
      win(10'h041, 1'b1);
      // Left justified with shifted thresholds
      left_j = 1'b1;
      apb(1'b1, adc_ctl_pkg::CTRL_ADDR, 32'h0000_0001);
      thr(16'h1000, 16'h2000);
      win(10'h041, 1'b1);
      win(10'h040, 1'b0);
      win(10'h3ff, 1'b0);
      // Interrupt raised, masked, cleared
      apb(1'b1, adc_ctl_pkg::MASK_ADDR, 32'h0000_0001);
      @(posedge pclk);
      start <= 1'b1;
      code_in <= 10'h041;
      @(posedge pclk);
      start <= 1'b0;
      repeat (3) @(posedge pclk);
      check("irq raised", irq, 1'b1);
      apb(1'b1, adc_ctl_pkg::MASK_ADDR, 32'h0000_0000);
      repeat (2) @(posedge pclk);
      check("irq masked", irq, 1'b0);
      apb(1'b1, adc_ctl_pkg::MASK_ADDR, 32'h0000_0001);
      repeat (2) @(posedge pclk);
      check("irq unmasked", irq, 1'b1);
      apb(1'b1, adc_ctl_pkg::STAT_ADDR, 32'h0000_0007);
      repeat (2) @(posedge pclk);
      check("irq cleared", irq, 1'b0);
      // Upper selector bits read zero
      apb(1'b1, adc_ctl_pkg::SEL_ADDR, 32'h0000_00e0);
      rdchk("sel upper", adc_ctl_pkg::SEL_ADDR, 32'h0000_0000);
      apb(1'b1, adc_ctl_pkg::SEL_ADDR, 32'h0000_00ff);
      rdchk("sel upper", adc_ctl_pkg::SEL_ADDR, 32'h0000_001f);
      // Every selector code
      for (int i = 0; i < 32; i++)
         set_sel(5'(i));
      // Sensor chosen straight from a pin sets the warning bit
      apb(1'b1, adc_ctl_pkg::MASK_ADDR, 32'h0000_0004);
      apb(1'b1, adc_ctl_pkg::SEL_ADDR, 32'h0000_0000);
      apb(1'b1, adc_ctl_pkg::SEL_ADDR, 32'h0000_001b);
      repeat (3) @(posedge pclk);
      rdchk("unsafe", adc_ctl_pkg::STAT_ADDR, 32'h0000_0004);
      check("irq unsafe", irq, 1'b1);
      // Unmapped address refused
      apb(1'b1, 12'h100, 32'h0000_0000);
      check("err wr", err, 1'b1);
      rdchk("unmapped", 12'h100, 32'h0000_0000);
      check("err rd", err, 1'b1);
      rdchk("sel kept", adc_ctl_pkg::SEL_ADDR, 32'h0000_001b);
      // Second reset in mid-run
      reset_check();
      final_report();
   end
endmodule
